// File: hw/hpcb_config_bytes.sv
// What this block does
// - Two-bit over-current delay, 50 to 400 ns
// - Compound flag reports compound device membership
// - Strap mode: any fixed port means compound
// - Remap select picks standard or remap numbering
// - Standard: port n, disabled ports close ranks
// - Standard enables from straps or disable registers
// - Remap numbers from two map registers
// - Fixed mask bits 1..3 flag ports
// - Default config uses two-bit fixed strap
// - Self-powered mask bits 1..3 disable ports
// - Self-powered disabled ports come back on when bus-powered
// - Report enabled count, contiguous order
// - Self-powered mask used only when self-powered
//
// Hub port configuration byte set: register file plus reported view.
// Assumes a same-clock register port and pin-level straps.
`timescale 1ns/1ns
`default_nettype none
`include "hpcb_params.svh"
module hpcb_config_bytes
  import hpcb_pkg::*;
#(
  parameter int PORTS = 3
) (
  input  wire logic            mclk_i,
  input  wire logic            sys_rst_i,
  input  wire logic            ce_i,
  input  wire hpcb_pkg::hpcb_req_type req_i,
  output logic      [7:0]      rdata_o,
  output logic                 rvalid_o,
  input  wire hpcb_pkg::hpcb_src_type src_i,
  input  wire logic            supply_source_sel_i,
  input  wire logic [1:0]      fixed_port_strap_i,
  input  wire logic [1:0]      port_off_strap_i,
  input  wire logic [3:1]      strap_fixed_i,
  output hpcb_pkg::hpcb_oc_type overcurrent_delay_sel_o,
  output logic      [4:0]      overcurrent_delay_cycles_o,
  output hpcb_pkg::hpcb_report_type report_o
);
  import hpcb_pkg::*;

  logic [7:0] config_byte_two_q;
  logic [7:0] config_byte_three_q;
  logic [7:0] fixed_port_mask_q;
  logic [7:0] selfpwr_port_off_q;
  logic [7:0] selfpwr_rt_q;
  logic [7:0] buspwr_rt_q;
  logic [7:0] map12_q;
  logic [7:0] map3_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic [7:0] reg_hit;
  logic [7:0] wr_en;
  logic [3:1] dflt_fixed;
  logic [3:1] strap_off;
  logic [3:1] sp_off;

  // Pin straps pass two flops before use
  logic       sup_m_q;
  logic       sup_q;
  logic [1:0] fstr_m_q;
  logic [1:0] fstr_q;
  logic [1:0] ostr_m_q;
  logic [1:0] ostr_q;
  logic [3:1] sfix_m_q;
  logic [3:1] sfix_q;

  logic [3:1] fixed_d;
  logic [3:1] fixed_q;
  logic [3:1] off_d;
  logic [3:1] enable_d;
  logic [3:1] enable_q;
  logic       compound_d;
  logic       compound_q;
  logic [2*PORTS:1] nums;
  logic [1:0] count;
  hpcb_oc_type oc_q;
  logic [4:0] oc_cyc_q;

  localparam int OC_CYC0 = (`HPCB_OC_BASE_NS + `HPCB_CLK_NS - 1) / `HPCB_CLK_NS;
  localparam int OC_CYC1 = (2 * `HPCB_OC_BASE_NS + `HPCB_CLK_NS - 1) / `HPCB_CLK_NS;
  localparam int OC_CYC2 = (4 * `HPCB_OC_BASE_NS + `HPCB_CLK_NS - 1) / `HPCB_CLK_NS;
  localparam int OC_CYC3 = (8 * `HPCB_OC_BASE_NS + `HPCB_CLK_NS - 1) / `HPCB_CLK_NS;

  // Bit positions in the one-hot register select
  localparam int SEL_CFG2  = 0;
  localparam int SEL_CFG3  = 1;
  localparam int SEL_FIXED = 2;
  localparam int SEL_SPOFF = 3;
  localparam int SEL_SPRT  = 4;
  localparam int SEL_BPRT  = 5;
  localparam int SEL_MAP12 = 6;
  localparam int SEL_MAP3  = 7;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sup_m_q  <= 1'b0;
      sup_q    <= 1'b0;
      fstr_m_q <= 2'h0;
      fstr_q   <= 2'h0;
      ostr_m_q <= 2'h0;
      ostr_q   <= 2'h0;
      sfix_m_q <= 3'h0;
      sfix_q   <= 3'h0;
    end else if (ce_i) begin
      sup_m_q  <= supply_source_sel_i;
      sup_q    <= sup_m_q;
      fstr_m_q <= fixed_port_strap_i;
      fstr_q   <= fstr_m_q;
      ostr_m_q <= port_off_strap_i;
      ostr_q   <= ostr_m_q;
      sfix_m_q <= strap_fixed_i;
      sfix_q   <= sfix_m_q;
    end
  end

  // One-hot register select for the write enables
  always_comb begin
    reg_hit = 8'h00;
    if (req_i.addr == `HPCB_ADDR_CFG2) begin
      reg_hit[SEL_CFG2] = 1'b1;
    end else if (req_i.addr == `HPCB_ADDR_CFG3) begin
      reg_hit[SEL_CFG3] = 1'b1;
    end else if (req_i.addr == `HPCB_ADDR_FIXED) begin
      reg_hit[SEL_FIXED] = 1'b1;
    end else if (req_i.addr == `HPCB_ADDR_SPOFF) begin
      reg_hit[SEL_SPOFF] = 1'b1;
    end else if (req_i.addr == `HPCB_ADDR_SPOFF_RT) begin
      reg_hit[SEL_SPRT] = 1'b1;
    end else if (req_i.addr == `HPCB_ADDR_BPOFF_RT) begin
      reg_hit[SEL_BPRT] = 1'b1;
    end else if (req_i.addr == `HPCB_ADDR_MAP12) begin
      reg_hit[SEL_MAP12] = 1'b1;
    end else if (req_i.addr == `HPCB_ADDR_MAP3) begin
      reg_hit[SEL_MAP3] = 1'b1;
    end
  end

  // Unmapped writes select nothing and are dropped
  assign wr_en = (ce_i && req_i.wr) ? reg_hit : 8'h00;

  // Reserved bits masked on the way in, so they always read zero
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      config_byte_two_q <= `HPCB_RESET_BYTE;
    end else if (wr_en[SEL_CFG2]) begin
      config_byte_two_q <= req_i.wdata & `HPCB_CFG2_WMASK;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      config_byte_three_q <= `HPCB_RESET_BYTE;
    end else if (wr_en[SEL_CFG3]) begin
      config_byte_three_q <= req_i.wdata & `HPCB_CFG3_WMASK;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fixed_port_mask_q <= `HPCB_RESET_BYTE;
    end else if (wr_en[SEL_FIXED]) begin
      fixed_port_mask_q <= req_i.wdata & `HPCB_PORT_WMASK;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      selfpwr_port_off_q <= `HPCB_RESET_BYTE;
    end else if (wr_en[SEL_SPOFF]) begin
      selfpwr_port_off_q <= req_i.wdata & `HPCB_PORT_WMASK;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      selfpwr_rt_q <= `HPCB_RESET_BYTE;
    end else if (wr_en[SEL_SPRT]) begin
      selfpwr_rt_q <= req_i.wdata & `HPCB_PORT_WMASK;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      buspwr_rt_q <= `HPCB_RESET_BYTE;
    end else if (wr_en[SEL_BPRT]) begin
      buspwr_rt_q <= req_i.wdata & `HPCB_PORT_WMASK;
    end
  end

  // Map bytes keep all eight bits; only the number fields are used
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      map12_q <= `HPCB_RESET_BYTE;
    end else if (wr_en[SEL_MAP12]) begin
      map12_q <= req_i.wdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      map3_q <= `HPCB_RESET_BYTE;
    end else if (wr_en[SEL_MAP3]) begin
      map3_q <= req_i.wdata;
    end
  end

  // Read strobe echoes one cycle later and holds under a low enable
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rvalid_q <= 1'b0;
    end else if (ce_i) begin
      rvalid_q <= req_i.rd;
    end
  end

  // Reads answer one cycle later; unmapped reads return zero
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      if (!req_i.rd) begin
        rdata_q <= rdata_q;
      end else if (req_i.addr == `HPCB_ADDR_CFG2) begin
        rdata_q <= config_byte_two_q;
      end else if (req_i.addr == `HPCB_ADDR_CFG3) begin
        rdata_q <= config_byte_three_q;
      end else if (req_i.addr == `HPCB_ADDR_FIXED) begin
        rdata_q <= fixed_port_mask_q;
      end else if (req_i.addr == `HPCB_ADDR_SPOFF) begin
        rdata_q <= selfpwr_port_off_q;
      end else if (req_i.addr == `HPCB_ADDR_SPOFF_RT) begin
        rdata_q <= selfpwr_rt_q;
      end else if (req_i.addr == `HPCB_ADDR_BPOFF_RT) begin
        rdata_q <= buspwr_rt_q;
      end else if (req_i.addr == `HPCB_ADDR_MAP12) begin
        rdata_q <= map12_q;
      end else if (req_i.addr == `HPCB_ADDR_MAP3) begin
        rdata_q <= map3_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // Per-port views; the two-bit straps never reach port 3
  genvar gp;
  generate
    for (gp = 1; gp <= 3; gp++) begin : g_port
      if (gp < 3) begin : g_strapped
        assign dflt_fixed[gp] = fstr_q[gp-1];
        assign strap_off[gp]  = ostr_q[gp-1];
      end else begin : g_bare
        assign dflt_fixed[gp] = 1'b0;
        assign strap_off[gp]  = 1'b0;
      end
      assign sp_off[gp] = selfpwr_port_off_q[gp] | selfpwr_rt_q[gp];
    end
  endgenerate

  // Fixed ports and disables by configuration source
  always_comb begin
    fixed_d  = fixed_port_mask_q[3:1];
    off_d    = 3'h0;
    if (src_i == SRC_DEFAULT) begin
      fixed_d = dflt_fixed;
      off_d   = strap_off;
    end else if (src_i == SRC_STRAP) begin
      fixed_d = sfix_q;
      off_d   = strap_off;
    end else if (sup_q) begin
      off_d = sp_off;
    end else begin
      off_d = buspwr_rt_q[3:1];
    end
    enable_d = ~off_d;
  end

  // Strap mode cannot express compound, so any fixed port implies it
  always_comb begin
    if (src_i == SRC_STRAP) begin
      compound_d = |fixed_d;
    end else begin
      compound_d = config_byte_two_q[`HPCB_COMPOUND_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fixed_q    <= 3'h0;
      enable_q   <= 3'h7;
      compound_q <= 1'b0;
    end else if (ce_i) begin
      fixed_q    <= fixed_d & enable_d;
      enable_q   <= enable_d;
      compound_q <= compound_d;
    end
  end

  // Delay code in ascending order; cycles round up
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      oc_q     <= OC_50NS;
      oc_cyc_q <= 5'(OC_CYC0);
    end else if (ce_i) begin
      oc_q <= hpcb_oc_type'(config_byte_two_q[`HPCB_OC_LSB +: 2]);
      case (config_byte_two_q[`HPCB_OC_LSB +: 2])
        2'h0:    oc_cyc_q <= 5'(OC_CYC0);
        2'h1:    oc_cyc_q <= 5'(OC_CYC1);
        2'h2:    oc_cyc_q <= 5'(OC_CYC2);
        default: oc_cyc_q <= 5'(OC_CYC3);
      endcase
    end
  end

  hpcb_port_numberer #(
    .PORTS (PORTS)
  ) u_numberer (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .remap_i   (config_byte_three_q[`HPCB_REMAP_BIT]),
    .enable_i  (enable_q),
    .map12_i   (map12_q),
    .map3_i    (map3_q),
    .nums_o    (nums),
    .count_o   (count)
  );

  assign rdata_o                    = rdata_q;
  assign rvalid_o                   = rvalid_q;
  assign overcurrent_delay_sel_o    = oc_q;
  assign overcurrent_delay_cycles_o = oc_cyc_q;
  assign report_o.count    = count;
  assign report_o.num1     = nums[2:1];
  assign report_o.num2     = nums[4:3];
  assign report_o.num3     = nums[6:5];
  assign report_o.fixed    = fixed_q;
  assign report_o.enabled  = enable_q;
  assign report_o.compound = compound_q;
endmodule
`default_nettype wire

// File: hw/hpcb_params.svh
// Offsets, field positions, reset values and timing values in ns of the hub
// port configuration byte block. Included by hw files only.
`ifndef HPCB_PARAMS_SVH
`define HPCB_PARAMS_SVH

`define HPCB_ADDR_CFG2        16'h00E5
`define HPCB_ADDR_CFG3        16'h00E6
`define HPCB_ADDR_FIXED       16'h00E7
`define HPCB_ADDR_SPOFF       16'h00E8
`define HPCB_ADDR_SPOFF_RT    16'h300A
`define HPCB_ADDR_BPOFF_RT    16'h300B
`define HPCB_ADDR_MAP12       16'h30FB
`define HPCB_ADDR_MAP3        16'h30FC

`define HPCB_CFG2_WMASK       8'h38
`define HPCB_CFG3_WMASK       8'h08
`define HPCB_PORT_WMASK       8'h0E
`define HPCB_OC_LSB           4
`define HPCB_COMPOUND_BIT     3
`define HPCB_REMAP_BIT        3
`define HPCB_RESET_BYTE       8'h00

`define HPCB_CLK_NS           40
`define HPCB_OC_BASE_NS       50

`endif

// File: hw/hpcb_pkg.sv
// Types shared by the hub port configuration byte block.
// Assumes hpcb_params.svh is on the include path.
package hpcb_pkg;

  typedef enum logic [1:0] {
    OC_50NS,
    OC_100NS,
    OC_200NS,
    OC_400NS
  } hpcb_oc_type;

  typedef enum logic [1:0] {
    SRC_CONFIG,
    SRC_STRAP,
    SRC_DEFAULT
  } hpcb_src_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } hpcb_req_type;

  typedef struct packed {
    logic [1:0] count;
    logic [1:0] num1;
    logic [1:0] num2;
    logic [1:0] num3;
    logic [3:1] fixed;
    logic [3:1] enabled;
    logic       compound;
  } hpcb_report_type;

endpackage

// File: hw/hpcb_port_numberer.sv
// Assigns reported port numbers from enables and remap bytes.
// Assumes a same-clock parent; output comes from flops.
`timescale 1ns/1ns
`default_nettype none
module hpcb_port_numberer
  import hpcb_pkg::*;
#(
  parameter int PORTS = 3
) (
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             ce_i,
  input  wire logic             remap_i,
  input  wire logic [PORTS:1]   enable_i,
  input  wire logic [7:0]       map12_i,
  input  wire logic [7:0]       map3_i,
  output logic      [2*PORTS:1] nums_o,
  output logic      [1:0]       count_o
);
  logic [2*PORTS:1] nums_d;
  logic [2*PORTS:1] nums_q;
  logic [1:0]       count_d;
  logic [1:0]       count_q;
  logic [1:0]       run [0:PORTS];
  logic [1:0]       mapv [1:PORTS];

  // Low two bits of a nibble per port in the map bytes, zero meaning unused
  assign mapv[1] = map12_i[1:0];
  assign mapv[2] = map12_i[5:4];
  assign mapv[3] = map3_i[1:0];
  assign run[0]  = 2'h0;

  genvar g;
  generate
    for (g = 1; g <= PORTS; g++) begin : g_port
      // Contiguous numbering skips disabled ports
      assign run[g] = run[g-1] + {1'b0, enable_i[g]};
      always_comb begin
        if (!enable_i[g]) begin
          nums_d[2*g -: 2] = 2'h0;
        end else if (remap_i) begin
          nums_d[2*g -: 2] = mapv[g];
        end else begin
          nums_d[2*g -: 2] = run[g];
        end
      end
    end
  endgenerate

  assign count_d = run[PORTS];

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      nums_q  <= '0;
      count_q <= 2'h0;
    end else if (ce_i) begin
      nums_q  <= nums_d;
      count_q <= count_d;
    end
  end

  assign nums_o  = nums_q;
  assign count_o = count_q;
endmodule
`default_nettype wire

// File: test/hpcb_config_bytes_asserts.sv
// Port checker for the configuration byte block.
// Assumes ce_i high in normal runs.
`timescale 1ns/1ns
`default_nettype none
module hpcb_config_bytes_chk (
  input wire logic                     mclk_i,
  input wire logic                     sys_rst_i,
  input wire logic                     ce_i,
  input wire hpcb_pkg::hpcb_req_type   req_i,
  input wire logic [7:0]               rdata_o,
  input wire logic                     rvalid_o,
  input wire hpcb_pkg::hpcb_src_type   src_i,
  input wire hpcb_pkg::hpcb_oc_type    overcurrent_delay_sel_o,
  input wire logic [4:0]               overcurrent_delay_cycles_o,
  input wire hpcb_pkg::hpcb_report_type report_o
);
  import hpcb_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_read_answer: assert property (ce_i && req_i.rd |=> rvalid_o)
    else $error("read not answered");
  a_rdata_hold: assert property (!req_i.rd |=> $stable(rdata_o))
    else $error("read data moved");
  a_cfg2_rsvd: assert property (ce_i && req_i.rd && req_i.addr == 16'h00E5 |=>
    (rdata_o & 8'hC7) == 8'h00) else $error("reserved bits read nonzero");
  a_oc_cycles: assert property (overcurrent_delay_cycles_o ==
    (overcurrent_delay_sel_o == OC_50NS ? 5'h02 : overcurrent_delay_sel_o == OC_100NS ? 5'h03 :
    overcurrent_delay_sel_o == OC_200NS ? 5'h05 : 5'h0A)) else $error("delay count wrong");
  a_port_count: assert property (!$past(sys_rst_i, 2) && $stable(report_o.enabled) |->
    int'(report_o.count) == $countones(report_o.enabled)) else $error("port count wrong");
  a_off_zero: assert property (!$past(sys_rst_i, 2) && $stable(report_o.enabled) |->
    (report_o.enabled[1] || report_o.num1 == 2'h0) && (report_o.enabled[2] ||
    report_o.num2 == 2'h0) && (report_o.enabled[3] || report_o.num3 == 2'h0))
    else $error("disabled port numbered");
  a_fixed_on: assert property ((report_o.fixed & ~report_o.enabled) == 3'h0)
    else $error("fixed flag on disabled port");
  a_strap_comp: assert property (!$past(sys_rst_i, 2) && $past(src_i) == SRC_STRAP |->
    report_o.compound == |report_o.fixed) else $error("strap compound wrong");
endmodule
bind hpcb_config_bytes hpcb_config_bytes_chk u_chk (.mclk_i, .sys_rst_i, .ce_i, .req_i,
  .rdata_o, .rvalid_o, .src_i, .overcurrent_delay_sel_o, .overcurrent_delay_cycles_o,
  .report_o);
`default_nettype wire

// File: test/hpcb_host_model.sv
// Host side view: checks the port numbers it would enumerate.
// Assumes report_o of the hub is wired straight in.
`timescale 1ns/1ns
`default_nettype none
module hpcb_host_model (
  input  wire hpcb_pkg::hpcb_report_type report_i,
  output logic                           seq_ok_o
);
  import hpcb_pkg::*;
  logic [3:0] seen;
  logic [2:0] want;
  // Port zero slot soaks up disabled ports
  always_comb begin
    seen = 4'h0;
    seen[report_i.num1] = 1'b1;
    seen[report_i.num2] = 1'b1;
    seen[report_i.num3] = 1'b1;
    want = 3'((4'h1 << report_i.count) - 4'h1);
    seq_ok_o = (seen[3:1] == want) && ($countones({report_i.num1 != 2'h0,
      report_i.num2 != 2'h0, report_i.num3 != 2'h0}) == int'(report_i.count));
  end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench: register rows, then report scenarios.
// Assumes hw package, checker and host model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hpcb_pkg::*;
  typedef struct packed {logic [15:0] a; logic [7:0] w; logic [7:0] e;} hpcb_row_type;
  logic            mclk_i = 1'b0;
  logic            sys_rst_i = 1'b1;
  logic            ce_i = 1'b1;
  logic            supply_source_sel_i = 1'b1;
  logic [1:0]      fixed_port_strap_i = 2'h0;
  logic [1:0]      port_off_strap_i = 2'h0;
  logic [3:1]      strap_fixed_i = 3'h0;
  hpcb_req_type    req_i = '0;
  hpcb_src_type    src_i = SRC_CONFIG;
  logic [7:0]      rdata_o;
  logic            rvalid_o;
  logic            seq_ok;
  logic [4:0]      overcurrent_delay_cycles_o;
  hpcb_oc_type     overcurrent_delay_sel_o;
  hpcb_report_type report_o;
  int              n_mismatch = 0;
  int              n_tests = 0;
  int              cyc = 0;
  hpcb_row_type rows [9] = '{'{16'h00E5, 8'hFF, 8'h38}, '{16'h00E6, 8'hFF, 8'h08},
    '{16'h00E7, 8'hFF, 8'h0E}, '{16'h00E8, 8'hFF, 8'h0E}, '{16'h300A, 8'hFF, 8'h0E},
    '{16'h300B, 8'hFF, 8'h0E}, '{16'h30FB, 8'hA5, 8'hA5}, '{16'h30FC, 8'h5A, 8'h5A},
    '{16'h1234, 8'hFF, 8'h00}};
  // Delays of 50 to 400 ns rounded up to whole 40 ns cycles
  logic [7:0]      oc_cyc [4] = '{8'h02, 8'h03, 8'h05, 8'h0A};
  hpcb_config_bytes u_hpcb_config_bytes (.mclk_i, .sys_rst_i, .ce_i, .req_i, .rdata_o,
    .rvalid_o, .src_i, .supply_source_sel_i, .fixed_port_strap_i, .port_off_strap_i,
    .strap_fixed_i, .overcurrent_delay_sel_o, .overcurrent_delay_cycles_o, .report_o);
  hpcb_host_model u_hpcb_host_model (.report_i(report_o), .seq_ok_o(seq_ok));
  always #20 mclk_i = ~mclk_i;
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Generous ceiling; the run needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Requests are left standing; the next call or idle replaces them
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    req_i = '{1'b1, 1'b0, a, d};
    tick(1);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    req_i = '{1'b0, 1'b1, a, 8'h00};
    tick(1);
    chk("rvalid", {7'h0, rvalid_o}, 8'h01);
    d = rdata_o;
  endtask
  task automatic idle(input int n);
    req_i = '0;
    tick(n);
  endtask
  task automatic cfg(input logic [7:0] c2, input logic [7:0] c3, input logic [7:0] fx,
                     input logic [7:0] sp);
    wr(16'h00E5, c2);
    wr(16'h00E6, c3);
    wr(16'h00E7, fx);
    wr(16'h00E8, sp);
    wr(16'h300A, 8'h00);
    wr(16'h300B, 8'h00);
  endtask
  // Waits out pin sync and the two-stage report pipeline
  task automatic rep(input logic [1:0] c, input logic [5:0] n, input logic [3:1] fx,
                     input logic cp);
    idle(8);
    chk("count", {6'h0, report_o.count}, {6'h0, c});
    chk("nums", {2'h0, report_o.num1, report_o.num2, report_o.num3}, {2'h0, n});
    chk("fixed", {5'h0, report_o.fixed}, {5'h0, fx});
    chk("compound", {7'h0, report_o.compound}, {7'h0, cp});
    chk("host", {7'h0, seq_ok}, 8'h01);
  endtask
  initial begin
    logic [7:0] d;
    tick(3);
    sys_rst_i = 1'b0;
    for (int i = 4; i < 8; i++) begin
      rd(rows[i].a, d);
      chk("reset", d, 8'h00);
    end
    foreach (rows[i]) wr(rows[i].a, rows[i].w);
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      chk("readback", d, rows[i].e);
    end
    for (int c = 0; c < 4; c++) begin
      cfg(8'(c << 4), 8'h00, 8'h00, 8'h00);
      idle(3);
      chk("oc", {6'h0, overcurrent_delay_sel_o}, 8'(c));
      chk("oc_cycles", {3'h0, overcurrent_delay_cycles_o}, oc_cyc[c]);
    end
    cfg(8'h00, 8'h00, 8'h00, 8'h02);
    rep(2'h2, 6'h06, 3'h0, 1'b0);
    supply_source_sel_i = 1'b0;
    rep(2'h3, 6'h1B, 3'h0, 1'b0);
    wr(16'h300B, 8'h08);
    rep(2'h2, 6'h18, 3'h0, 1'b0);
    supply_source_sel_i = 1'b1;
    cfg(8'h08, 8'h00, 8'h0E, 8'h00);
    rep(2'h3, 6'h1B, 3'h7, 1'b1);
    cfg(8'h00, 8'h08, 8'h02, 8'h04);
    wr(16'h30FB, 8'h02);
    wr(16'h30FC, 8'h01);
    rep(2'h2, 6'h21, 3'h1, 1'b0);
    cfg(8'h00, 8'h00, 8'h00, 8'h00);
    src_i = SRC_STRAP;
    port_off_strap_i = 2'h1;
    strap_fixed_i = 3'h4;
    rep(2'h2, 6'h06, 3'h4, 1'b1);
    src_i = SRC_DEFAULT;
    port_off_strap_i = 2'h0;
    fixed_port_strap_i = 2'h2;
    rep(2'h3, 6'h1B, 3'h2, 1'b0);
    sys_rst_i = 1'b1;
    tick(3);
    sys_rst_i = 1'b0;
    rd(16'h300A, d);
    chk("rereset", d, 8'h00);
    idle(1);
    chk("rvalid_drop", {7'h0, rvalid_o}, 8'h00);
    ce_i = 1'b0;
    wr(16'h00E5, 8'h30);
    idle(2);
    ce_i = 1'b1;
    chk("oc_frozen", {6'h0, overcurrent_delay_sel_o}, 8'h00);
    rd(16'h00E5, d);
    chk("cfg2_frozen", d, 8'h00);
    idle(2);
    end_sim();
  end
endmodule
`default_nettype wire
